// *** vcap_pkg.sv ***
// Register map, field positions and state codes of the video capture path.
package vcap_pkg;
    // Register byte offsets.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_GAIN = 8'h04;
    localparam logic [7:0] A_CORE = 8'h08;
    localparam logic [7:0] A_COUNT = 8'h0C;
    localparam logic [7:0] A_ACQX = 8'h10;
    localparam logic [7:0] A_ACQY = 8'h14;
    localparam logic [7:0] A_ROIX = 8'h18;
    localparam logic [7:0] A_ROIY = 8'h1C;
    localparam logic [7:0] A_LUT = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;
    localparam logic [7:0] A_WPTR = 8'h28;
    localparam logic [7:0] A_DMA0 = 8'h30;
    localparam logic [7:0] A_STEP = 8'h04;
    localparam logic [7:0] A_CFGID = 8'h00;
    // Control register bit positions.
    localparam int C_GAIN = 0;
    localparam int C_LUT = 1;
    localparam int C_HSL = 2;
    localparam int C_CORE = 3;
    localparam int C_FMT = 4;
    localparam int C_PLANE = 6;
    localparam int C_TSTART = 9;
    localparam int C_TEDGE = 10;
    localparam int C_TDIR = 11;
    localparam int C_TPOL = 12;
    localparam int C_TSRC = 13;
    localparam int C_TSW = 15;
    localparam int C_SWGO = 16;
    localparam int C_FRAME = 17;
    localparam int C_ODD = 18;
    localparam int C_ROI = 19;
    localparam int C_PDEC = 20;
    localparam int C_LDEC = 22;
    localparam int C_FIFO = 24;
    // Window register fields: start and count.
    localparam int F_ST = 0;
    localparam int F_CT = 16;
    // Output formats.
    localparam logic [1:0] FMT_RGB = 2'h0;
    localparam logic [1:0] FMT_HSL = 2'h1;
    localparam logic [1:0] FMT_PLANE = 2'h2;
    // Gain is 2.6 fixed point, so 8'h40 is unity.
    localparam int GAIN_FRAC = 6;
    localparam logic [31:0] GAIN_RST = 32'h0040_4040;
    // Hue sector bases and span.
    localparam int HUE_G = 85;
    localparam int HUE_B = 171;
    localparam int HUE_SPAN = 42;
    // Number of words loaded from nonvolatile storage at power-up.
    localparam logic [3:0] NV_WORDS = 4'h8;
    // Configuration identity word; the value is arbitrary.
    localparam logic [31:0] CFG_ID = 32'h0A5C_0001;
    typedef enum logic [2:0] {
        ACQ_IDLE = 3'b001,
        ACQ_WAIT = 3'b010,
        ACQ_CAPT = 3'b100
    } vcap_acq_t;
    typedef enum logic [5:0] {
        D_IDLE = 6'b000001,
        D_FETCH = 6'b000010,
        D_SRD = 6'b000100,
        D_SCAP = 6'b001000,
        D_WR = 6'b010000,
        D_NEXT = 6'b100000
    } vcap_dma_t;
endpackage

// *** vcap_top.sv ***
// Colour video acquisition path: processing, capture, buffer feed and DMA.
//
// How it works
// - Decoded RGB pixels enter and feed the colour-space stages.
// - Line and field pulses from the decoder drive all capture timing.
// - Each processing step has its own enable; disabled steps pass data.
// - Each of R, G and B has its own programmable gain.
// - Three loadable lookup tables, one per colour channel.
// - When enabled, pixels are converted to hue, saturation, luminance.
// - Coring clears hue where saturation is below a threshold.
// - Output is a 32-bit RGB or HSL word or one packed 8-bit plane.
// - Buffer memory is 16 MB; FIFO mode makes DMA wait for new data.
// - Trigger edge of chosen polarity starts an acquisition when enabled.
// - Trigger pin set as output drives the software written level, inverted when the polarity bit is set.
// - A chosen status signal may drive the trigger pin, with polarity.
// - Only active pixels inside window, scaling and region are stored.
// - Pixel and line scaling keep one in two, four or eight.
// - Region mode stores only the programmed rectangle.
// - Three DMA engines move buffer data to the host bus.
// - Engines walk descriptor chains, loading the next without stopping.
// - Master writes may be 8, 16 or 32 bits, single or burst.
// - The master can fetch one descriptor word per clock when acknowledged; write beats take three clocks.
// - Target port answers memory and configuration reads a cycle later.
// - The eight registers from A_CTRL to A_ROIY load from nonvolatile storage at reset.
// - Software start captures a programmed number of fields or frames.
// - Frame mode may start on an odd or an even field.
// - Pixel and line scaling each offer one, two, four or eight.
`timescale 1ns/10ps
module vcap_top
    import vcap_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic regCfg,
    output logic [31:0] regRData,
    // Decoded video.
    input wire logic vidValid,
    input wire logic [7:0] vidR,
    input wire logic [7:0] vidG,
    input wire logic [7:0] vidB,
    input wire logic vidLine,
    input wire logic vidFrame,
    input wire logic vidOdd,
    // Buffer memory.
    output logic memWr,
    output logic [21:0] memAddr,
    output logic [31:0] memData,
    output logic memRd,
    output logic [21:0] memRdAddr,
    input wire logic [31:0] memRdData,
    // Host bus master.
    output logic mReq,
    output logic mWrite,
    output logic [31:0] mAddr,
    output logic [3:0] mBe,
    output logic [31:0] mWData,
    output logic mLast,
    input wire logic mAck,
    input wire logic [31:0] mRData,
    // Nonvolatile storage.
    output logic nvRd,
    output logic [2:0] nvAddr,
    input wire logic [31:0] nvData,
    // Trigger pin.
    input wire logic trigIn,
    output logic trigOut,
    output logic trigOe_n
);
    typedef struct packed {
        logic [7:0][31:0] cfg;
        logic [2:0][255:0][7:0] lut;
        logic [31:0] rdData;
        logic loading;
        logic [3:0] nvIdx;
        logic nvPend;
        logic [2:0] nvWIdx;
        vcap_acq_t acq;
        logic [15:0] remain;
        logic phase;
        logic newF;
        logic [11:0] x;
        logic [11:0] y;
        logic trigPrev;
        logic trigOut;
        logic v1;
        logic [2:0][7:0] c1;
        logic v2;
        logic [2:0][7:0] c2;
        logic [1:0] lane;
        logic [23:0] pack;
        logic memWr;
        logic [21:0] memAddr;
        logic [31:0] memData;
        logic [21:0] wrPtr;
        vcap_dma_t dma;
        logic [1:0] eng;
        logic [1:0] fIdx;
        logic [2:0] act;
        logic [2:0][31:0] desc;
        logic [2:0][1:0] wid;
        logic [31:0] hAddr;
        logic [31:0] cnt;
        logic [21:0] sAddr;
        logic [31:0] next;
        logic [31:0] mAddr;
        logic [3:0] mBe;
        logic [31:0] mWData;
    } vcap_state_t;

    vcap_state_t s;
    vcap_state_t n;

    // Gain with saturation at full scale.
    function automatic logic [7:0] gainf(input logic [7:0] v,
        input logic [7:0] g);
        logic [15:0] p;
        logic [15:0] q;
        p = 16'(v) * 16'(g);
        q = p >> GAIN_FRAC;
        gainf = (q > 16'h00FF) ? 8'hFF : q[7:0];
    endfunction

    // True when a position falls in a window and on the scaling grid.
    function automatic logic inwin(input logic [11:0] p,
        input logic [11:0] st, input logic [11:0] ct,
        input logic [1:0] dec);
        logic [11:0] off;
        logic [11:0] mask;
        off = p - st;
        mask = (12'h001 << dec) - 12'h001;
        inwin = (p >= st) && (off < ct) && ((off & mask) == 12'h000);
    endfunction

    // Hue from the sector of the largest channel.
    function automatic logic [7:0] huef(input logic [7:0] r,
        input logic [7:0] g, input logic [7:0] b, input logic [7:0] mx,
        input logic [7:0] d);
        int num;
        int base;
        if (mx == r)
        begin
            base = 0;
            num = int'(g) - int'(b);
        end
        else if (mx == g)
        begin
            base = HUE_G;
            num = int'(b) - int'(r);
        end
        else
        begin
            base = HUE_B;
            num = int'(r) - int'(g);
        end
        huef = (d == 8'h00) ? 8'h00 : 8'(base + (num * HUE_SPAN) / int'(d));
    endfunction

    logic [31:0] ctrl;
    logic [11:0] xPos;
    logic keepX;
    logic keepY;
    logic keepIn;
    logic trigEdge;
    logic trigGo;
    logic swGo;
    logic [7:0] mx;
    logic [7:0] mn;
    logic [7:0] sat;
    logic [8:0] lsum;
    logic [7:0] hOut;
    logic [23:0] rgb;
    logic [23:0] hv;
    logic [47:0] planes;
    logic [7:0] pByte;
    logic [2:0] step;
    logic [31:0] stepW;

    assign ctrl = s.cfg[0];
    assign xPos = vidLine ? 12'h000 : s.x;

    // Window, region and scaling select on pixels and lines.
    assign keepX = inwin(xPos, s.cfg[4][F_ST +: 12], s.cfg[4][F_CT +: 12],
        ctrl[C_PDEC +: 2]) && (!ctrl[C_ROI] || inwin(xPos,
        s.cfg[4][F_ST +: 12] + s.cfg[6][F_ST +: 12],
        s.cfg[6][F_CT +: 12], 2'h0));
    assign keepY = inwin(s.y, s.cfg[5][F_ST +: 12], s.cfg[5][F_CT +: 12],
        ctrl[C_LDEC +: 2]) && (!ctrl[C_ROI] || inwin(s.y,
        s.cfg[5][F_ST +: 12] + s.cfg[7][F_ST +: 12],
        s.cfg[7][F_CT +: 12], 2'h0));
    assign keepIn = vidValid && !vidFrame && s.acq == ACQ_CAPT && keepX &&
        keepY;

    // Start sources: trigger edge and software strobe.
    assign trigEdge = (trigIn != s.trigPrev) && (trigIn != ctrl[C_TEDGE]);
    assign trigGo = ctrl[C_TSTART] && !ctrl[C_TDIR] && trigEdge;
    assign swGo = regWr && !regCfg && !s.loading && regAddr == A_CTRL &&
        regWData[C_SWGO];

    // Colour conversion on the looked-up pixel.
    assign mx = (s.c2[0] >= s.c2[1] && s.c2[0] >= s.c2[2]) ? s.c2[0] :
        (s.c2[1] >= s.c2[2] ? s.c2[1] : s.c2[2]);
    assign mn = (s.c2[0] <= s.c2[1] && s.c2[0] <= s.c2[2]) ? s.c2[0] :
        (s.c2[1] <= s.c2[2] ? s.c2[1] : s.c2[2]);
    assign sat = mx - mn;
    assign lsum = {1'b0, mx} + {1'b0, mn};
    assign hOut = (ctrl[C_CORE] && sat < s.cfg[2][7:0]) ? 8'h00 :
        huef(s.c2[0], s.c2[1], s.c2[2], mx, sat);
    // Channels packed with red in the top byte, so plane 0 selects red.
    assign rgb = {s.c2[0], s.c2[1], s.c2[2]};
    assign hv = ctrl[C_HSL] ? {hOut, sat, lsum[8:1]} : rgb;
    assign planes = {rgb, hv};
    assign pByte = (ctrl[C_PLANE +: 3] > 3'h5) ? 8'h00 :
        planes[8'd47 - {ctrl[C_PLANE +: 3], 3'h0} -: 8];

    // Transfer step in bytes for the active engine width.
    assign step = (s.wid[s.eng] == 2'h0) ? 3'h4 :
        (s.wid[s.eng] == 2'h1 ? 3'h2 : 3'h1);
    assign stepW = {29'h0, step};

    // Next state of the whole block.
    always_comb
    begin
        n = s;
        n.memWr = 1'b0;
        n.nvPend = 1'b0;
        // Power-up load of configuration words.
        if (nvRd)
        begin
            n.nvIdx = s.nvIdx + 4'h1;
            n.nvPend = 1'b1;
            n.nvWIdx = s.nvIdx[2:0];
        end
        if (s.nvPend)
            n.cfg[s.nvWIdx] = nvData;
        if (s.loading && s.nvIdx == NV_WORDS && !s.nvPend)
            n.loading = 1'b0;
        // Register writes from the target port.
        if (regWr && !regCfg && !s.loading)
        begin
            if (regAddr < A_LUT)
                n.cfg[regAddr[4:2]] = regWData;
            else if (regAddr == A_LUT && regWData[17:16] != 2'h3)
                n.lut[regWData[17:16]][regWData[15:8]] = regWData[7:0];
            for (int i = 0; i < 3; i++)
            begin
                if (regAddr == A_DMA0 + 8'(i) * A_STEP)
                begin
                    n.desc[i] = {regWData[31:2], 2'h0};
                    n.wid[i] = regWData[1:0];
                    n.act[i] = regWData[31:2] != 30'h0;
                end
            end
        end
        n.cfg[0][C_SWGO] = 1'b0;
        // Register reads, answered one cycle later.
        if (regRd)
        begin
            if (regCfg)
                n.rdData = (regAddr == A_CFGID) ? CFG_ID : 32'h0;
            else if (regAddr < A_LUT)
                n.rdData = s.cfg[regAddr[4:2]];
            else if (regAddr == A_STAT)
                n.rdData = {s.remain, 8'h00, trigIn, s.act, s.loading, s.acq};
            else if (regAddr == A_WPTR)
                n.rdData = {10'h0, s.wrPtr};
            else
                n.rdData = 32'h0;
            for (int i = 0; i < 3; i++)
                if (regAddr == A_DMA0 + 8'(i) * A_STEP)
                    n.rdData = {s.desc[i][31:2], s.wid[i]};
        end
        // Pixel and line counters from decoder sync.
        if (vidFrame)
            n.newF = 1'b1;
        if (vidLine)
        begin
            n.x = 12'h000;
            n.y = s.newF ? 12'h000 : s.y + 12'h001;
            n.newF = 1'b0;
        end
        if (vidValid)
            n.x = xPos + 12'h001;
        // Acquisition sequencing.
        n.trigPrev = trigIn;
        unique case (s.acq)
            ACQ_IDLE:
                if ((swGo || trigGo) && !s.loading)
                begin
                    n.acq = ACQ_WAIT;
                    n.remain = s.cfg[3][15:0];
                end
            ACQ_WAIT:
                if (vidFrame && (!ctrl[C_FRAME] || vidOdd == ctrl[C_ODD]))
                begin
                    n.acq = ACQ_CAPT;
                    n.phase = 1'b0;
                end
            ACQ_CAPT:
                if (vidFrame)
                begin
                    if (ctrl[C_FRAME] && !s.phase)
                        n.phase = 1'b1;
                    else
                    begin
                        n.phase = 1'b0;
                        n.remain = s.remain - 16'h0001;
                        if (s.remain <= 16'h0001)
                            n.acq = ACQ_IDLE;
                    end
                end
        endcase
        // Trigger output: software level or a mapped status.
        unique case (ctrl[C_TSRC +: 2])
            2'h0: n.trigOut = ctrl[C_TSW] ^ ctrl[C_TPOL];
            2'h1: n.trigOut = (s.acq == ACQ_CAPT) ^ ctrl[C_TPOL];
            2'h2: n.trigOut = (s.acq == ACQ_WAIT) ^ ctrl[C_TPOL];
            2'h3: n.trigOut = (|s.act) ^ ctrl[C_TPOL];
        endcase
        // Gain and lookup stages, each bypassed when off.
        n.v1 = keepIn;
        n.c1[0] = ctrl[C_GAIN] ? gainf(vidR, s.cfg[1][7:0]) : vidR;
        n.c1[1] = ctrl[C_GAIN] ? gainf(vidG, s.cfg[1][15:8]) : vidG;
        n.c1[2] = ctrl[C_GAIN] ? gainf(vidB, s.cfg[1][23:16]) : vidB;
        n.v2 = s.v1;
        for (int c = 0; c < 3; c++)
            n.c2[c] = ctrl[C_LUT] ? s.lut[c][s.c1[c]] : s.c1[c];
        // Format and write into the buffer.
        if (s.v2)
        begin
            if (ctrl[C_FMT +: 2] == FMT_PLANE)
            begin
                n.pack = {pByte, s.pack[23:8]};
                n.lane = s.lane + 2'h1;
                n.memWr = s.lane == 2'h3;
                n.memData = {pByte, s.pack[23:0]};
            end
            else
            begin
                n.memWr = 1'b1;
                n.memData = {8'h00,
                    (ctrl[C_FMT +: 2] == FMT_HSL) ? hv : rgb};
            end
        end
        if (n.memWr)
        begin
            n.memAddr = s.wrPtr;
            n.wrPtr = s.wrPtr + 22'h1;
        end
        // Descriptor-driven DMA engines sharing one master.
        unique case (s.dma)
            D_IDLE:
                for (int k = 3; k >= 1; k--)
                begin
                    if (s.act[(32'(s.eng) + k) % 3])
                    begin
                        n.eng = 2'((32'(s.eng) + k) % 3);
                        n.dma = D_FETCH;
                        n.fIdx = 2'h0;
                        n.mAddr = s.desc[(32'(s.eng) + k) % 3];
                    end
                end
            D_FETCH:
                if (mAck)
                begin
                    unique case (s.fIdx)
                        2'h0: n.hAddr = mRData;
                        2'h1: n.cnt = mRData;
                        2'h2: n.sAddr = mRData[21:0];
                        2'h3: n.next = mRData;
                    endcase
                    n.fIdx = s.fIdx + 2'h1;
                    n.mAddr = s.mAddr + 32'h4;
                    if (s.fIdx == 2'h3)
                        n.dma = (s.cnt == 32'h0) ? D_NEXT : D_SRD;
                end
            D_SRD:
                if (!(ctrl[C_FIFO] && s.sAddr == s.wrPtr))
                    n.dma = D_SCAP;
            D_SCAP:
            begin
                n.mWData = memRdData;
                n.mAddr = s.hAddr;
                n.dma = D_WR;
                if (s.wid[s.eng] == 2'h0)
                    n.mBe = 4'hF;
                else if (s.wid[s.eng] == 2'h1)
                    n.mBe = s.hAddr[1] ? 4'hC : 4'h3;
                else
                    n.mBe = 4'h1 << s.hAddr[1:0];
            end
            D_WR:
                if (mAck)
                begin
                    n.hAddr = s.hAddr + stepW;
                    n.cnt = (s.cnt > stepW) ? s.cnt - stepW : 32'h0;
                    if (n.hAddr[1:0] == 2'h0)
                        n.sAddr = s.sAddr + 22'h1;
                    n.dma = (s.cnt > stepW) ? D_SRD : D_NEXT;
                end
            D_NEXT:
            begin
                n.desc[s.eng] = s.next;
                n.act[s.eng] = s.next != 32'h0;
                n.dma = D_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.cfg[1] <= GAIN_RST;
            s.loading <= 1'b1;
            s.acq <= ACQ_IDLE;
            s.dma <= D_IDLE;
        end
        else
            s <= n;
    end

    // Outputs; handshake strobes are decoded from state.
    assign regRData = s.rdData;
    assign memWr = s.memWr;
    assign memAddr = s.memAddr;
    assign memData = s.memData;
    assign memRd = s.dma == D_SRD && !(ctrl[C_FIFO] && s.sAddr == s.wrPtr);
    assign memRdAddr = s.sAddr;
    assign mReq = s.dma == D_FETCH || s.dma == D_WR;
    assign mWrite = s.dma == D_WR;
    assign mAddr = s.mAddr;
    assign mBe = s.dma == D_FETCH ? 4'hF : s.mBe;
    assign mWData = s.mWData;
    assign mLast = (s.dma == D_FETCH && s.fIdx == 2'h3) ||
        (s.dma == D_WR && s.cnt <= stepW);
    assign nvRd = s.loading && s.nvIdx < NV_WORDS;
    assign nvAddr = s.nvIdx[2:0];
    assign trigOut = s.trigOut;
    assign trigOe_n = !ctrl[C_TDIR];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence pixRaw;
        keepIn && ctrl[3:0] == 4'h0 && ctrl[C_FMT +: 2] == FMT_RGB;
    endsequence
    sequence ctrlHeld;
        $stable(ctrl) ##1 $stable(ctrl);
    endsequence

    a_pass_thru:
    assert property (pixRaw ##1 ctrlHeld |=> memWr &&
        memData[23:0] == $past({vidR, vidG, vidB}, 3))
    else $error("Bypassed pixel not written unchanged.");

    a_gain_apply:
    assert property (keepIn && ctrl[C_GAIN] |=>
        s.c1[1] == gainf($past(vidG), $past(s.cfg[1][15:8])))
    else $error("Green gain not applied.");

    a_lut_apply:
    assert property (s.v1 && ctrl[C_LUT] |=>
        s.c2[0] == $past(s.lut[0][s.c1[0]]))
    else $error("Red lookup not applied.");

    a_core_clear:
    assert property (s.v2 && ctrl[C_CORE] && ctrl[C_HSL] &&
        ctrl[C_FMT +: 2] == FMT_HSL && sat < s.cfg[2][7:0] |=>
        memWr && memData[23:16] == 8'h00)
    else $error("Hue not cleared below threshold.");

    a_trig_start:
    assert property (s.acq == ACQ_IDLE && trigGo && !s.loading |=>
        s.acq == ACQ_WAIT)
    else $error("Trigger edge did not arm capture.");

    a_trig_drive:
    assert property (ctrl[C_TDIR] && ctrl[C_TSRC +: 2] == 2'h0 &&
        $stable(ctrl) |-> !trigOe_n && trigOut == (ctrl[C_TSW] ^ ctrl[C_TPOL]))
    else $error("Trigger output level wrong.");

    a_wait_frame:
    assert property (s.acq == ACQ_WAIT && !vidFrame |=> s.acq != ACQ_CAPT)
    else $error("Capture began outside a field start.");

    a_cap_stop:
    assert property (s.acq == ACQ_CAPT && vidFrame && s.remain <= 16'h0001 &&
        (!ctrl[C_FRAME] || s.phase) |=> s.acq == ACQ_IDLE)
    else $error("Capture did not stop at count.");

    a_desc_next:
    assert property (s.dma == D_NEXT |=> s.dma == D_IDLE &&
        s.desc[$past(s.eng)] == $past(s.next))
    else $error("Next descriptor not loaded.");

    a_fifo_wait:
    assert property (s.dma == D_SRD && ctrl[C_FIFO] && s.sAddr == s.wrPtr
        |-> !memRd ##1 s.dma == D_SRD)
    else $error("DMA read ahead of written data.");

    a_load_block:
    assert property (s.loading |-> s.acq == ACQ_IDLE && !mReq)
    else $error("Activity during configuration load.");
endmodule // vcap_top

// *** vcap_host_model.sv ***
// Host memory model that answers the block's bus master requests.
`timescale 1ns/10ps
module vcap_host_model
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Master side.
    input wire logic mReq,
    input wire logic mWrite,
    input wire logic [31:0] mAddr,
    input wire logic [3:0] mBe,
    input wire logic [31:0] mWData,
    input wire logic [3:0] delay,
    output logic mAck,
    output logic [31:0] mRData
);
    logic [31:0] mem [0:63];
    logic [3:0] waitCnt;

    // Acknowledges each beat after the set delay; byte enables gate writes.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mAck <= 1'b0;
            waitCnt <= 4'h0;
            mRData <= 32'h0;
        end
        else if (mReq && !mAck && waitCnt >= delay)
        begin
            mAck <= 1'b1;
            waitCnt <= 4'h0;
            mRData <= mem[mAddr[7:2]];
            for (int i = 0; i < 4; i++)
                if (mWrite && mBe[i])
                    mem[mAddr[7:2]][8*i+:8] <= mWData[8*i+:8];
        end
        else
        begin
            mAck <= 1'b0;
            waitCnt <= mReq ? waitCnt + 4'h1 : 4'h0;
            mRData <= ~mRData; // Stale data is never left standing.
        end
    end
endmodule // vcap_host_model

// *** vcap_tb.sv ***
// Self-checking bench of the video capture path.
`timescale 1ns/10ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin nErrors++; \
    $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module video_color_acquisition_path_test
    import vcap_pkg::*;
;
    logic clock = 0, resetn = 0, regWr = 0, regRd = 0, regCfg = 0;
    logic [7:0] regAddr = 0, vidR = 0;
    logic [31:0] regWData = 0, regRData, memData, memRdData = 0, mAddr;
    logic [31:0] mWData, mRData, nvData = 0, r;
    logic vidValid = 0, vidLine = 0, vidFrame = 0, vidOdd = 1, memWr, mLast;
    logic memRd, mReq, mWrite, mAck, nvRd, trigOut, trigOe_n, trigDrv = 0;
    logic [21:0] memAddr, memRdAddr;
    logic [3:0] mBe, delay = 0;
    logic [2:0] nvAddr;
    wire logic trigIn = trigOe_n ? trigDrv : trigOut;
    wire logic [7:0] vidG = vidR + 8'h40, vidB = vidR + 8'h80;
    int nErrors = 0, nCompared = 0, cycles = 0, nLast = 0;
    logic [31:0] words[$];

    vcap_top dut (.clock, .resetn, .regAddr, .regWData, .regWr, .regRd,
        .regCfg, .regRData, .vidValid, .vidR, .vidG, .vidB,
        .vidLine, .vidFrame, .vidOdd, .memWr, .memAddr, .memData, .memRd,
        .memRdAddr, .memRdData, .mReq, .mWrite, .mAddr, .mBe, .mWData,
        .mLast, .mAck, .mRData, .nvRd, .nvAddr, .nvData,
        .trigIn, .trigOut, .trigOe_n);
    vcap_host_model host (.clock, .resetn, .mReq, .mWrite, .mAddr, .mBe,
        .mWData, .delay, .mAck, .mRData);

    // Clock, cycle ceiling, storage answers and capture log.
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nErrors++;
            finishTest();
        end
        nvData <= nvAddr == 3'h1 ? GAIN_RST : {29'h0, nvAddr == 3'h2, 2'h0};
        memRdData <= {10'h0, memRdAddr} ^ 32'hA5A5_0000;
        if (memWr)
            words.push_back(memData);
        if (mAck && mLast)
            nLast++;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWData <= d;
        regWr <= 1;
        @(posedge clock);
        regWr <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic c);
        @(posedge clock);
        regAddr <= a;
        regCfg <= c;
        regRd <= 1;
        @(posedge clock);
        regRd <= 0;
        regCfg <= 0;
        #1 r = regRData;
    endtask

    // One field: frame pulse, line pulse, n colour ramp pixels, closing frame pulse.
    task automatic field(input int n, input logic [7:0] v);
        @(posedge clock) vidFrame <= 1;
        @(posedge clock) {vidFrame, vidLine} <= 2'b01;
        for (int i = 0; i < n; i++)
            @(posedge clock) {vidLine, vidValid, vidR} <= {2'b01, v + 8'(i)};
        @(posedge clock) vidValid <= 0;
        repeat (2) @(posedge clock) vidFrame <= ~vidFrame;
        repeat (8) @(posedge clock);
    endtask

    task automatic testLoad();
        rd(A_CORE, 0);
        `CHK(r[7:0], 8'h04)
        rd(A_STAT, 0);
        `CHK(r[3:0], 4'h1)
        rd(A_CFGID, 1);
        `CHK(r, CFG_ID)
        $display("Test load done");
    endtask

    task automatic testTrigger();
        wr(A_CTRL, 32'h0000_8800);
        repeat (2) @(posedge clock);
        `CHK({trigOe_n, trigOut}, 2'b01)
        rd(A_STAT, 0);
        `CHK(r[7], 1'b1)
        wr(A_CTRL, 32'h0000_9800);
        repeat (2) @(posedge clock);
        `CHK(trigOut, 1'b0)
        wr(A_CTRL, 32'h0);
        repeat (2) @(posedge clock);
        `CHK(trigOe_n, 1'b1)
        $display("Test trigger done");
    endtask

    task automatic testCapture();
        wr(A_ACQX, 32'h0008_0000);
        wr(A_ACQY, 32'h0001_0000);
        wr(A_COUNT, 32'h1);
        wr(A_CTRL, 32'h0001_0000);
        field(4, 8'h30);
        `CHK(words.size(), 4)
        `CHK(words[3][23:0], 24'h3373B3)
        words = {};
        wr(A_CTRL, 32'h0010_0220);
        @(posedge clock) trigDrv <= 1;
        rd(A_STAT, 0);
        `CHK(r[2:0], 3'h2)
        field(8, 8'h10);
        `CHK(words.size(), 1)
        `CHK(words[0], 32'h1614_1210)
        $display("Test capture done");
    endtask

    // Gain on green, all three tables, HSL word with the hue cored away.
    task automatic testColour();
        wr(A_GAIN, 32'h0040_8040);
        wr(A_CORE, 32'h0000_00FF);
        wr(A_LUT, 32'h0000_1020);
        wr(A_LUT, 32'h0001_A060);
        wr(A_LUT, 32'h0002_9062);
        words = {};
        wr(A_CTRL, 32'h0001_001F);
        field(1, 8'h10);
        `CHK(words.size(), 1)
        `CHK(words[0], 32'h0000_4241)
        rd(A_WPTR, 0);
        `CHK(r, 32'h0000_0006)
        $display("Test colour done");
    endtask

    task automatic testDma();
        host.mem[16] = 32'h80;
        host.mem[17] = 4;
        host.mem[18] = 5;
        host.mem[19] = 32'h50;
        host.mem[20] = 32'h84;
        host.mem[21] = 4;
        host.mem[22] = 9;
        host.mem[23] = 0;
        delay <= 3;
        wr(A_DMA0 + A_STEP, 32'h40);
        for (int i = 0; i < 100 && (i < 2 || r[6:4] != 0); i++)
            rd(A_STAT, 0);
        `CHK(host.mem[32], 32'hA5A5_0005)
        `CHK(host.mem[33], 32'hA5A5_0009)
        `CHK(r[6:4], 3'h0)
        `CHK(nLast, 4)
        $display("Test dma done");
    endtask

    task automatic finishTest();
        $display("Compared %0d, errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Reset for two cycles, wait for the power-up load, then run tests.
    initial
    begin
        repeat (2) @(posedge clock);
        resetn <= 1;
        repeat (20) @(posedge clock);
        testLoad();
        testTrigger();
        testCapture();
        testColour();
        testDma();
        finishTest();
    end
endmodule // video_color_acquisition_path_test
